// ---- rtl/mmtu_top.v ----
// Purpose: multi mode timer unit: core timer plus three general timers
// Assumes: single 125 MHz clock, synchronous active high reset
// Notes:   register port with read data one cycle after the strobe
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "mmtu_map.vh"

module mmtu_top (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // interrupt
  output wire        o_irq,
  // core timer expiry pin
  output reg         o_core_expiry_output_pin,
  // general timer pins, three signals each
  input  wire [2:0]  i_tmr_pin,
  output wire [2:0]  o_tmr_pin,
  output wire [2:0]  o_tmr_pin_oe_n
);

  //////////////////////////////////////////////////////////////////////////
  // registers
  reg [2:0]  ctrl_q;
  reg [1:0]  core_cfg_q;
  reg [31:0] core_per_q;
  reg [31:0] core_cnt_q;
  reg [`MMTU_IRQ_W-1:0] stat_q;
  reg [`MMTU_IRQ_W-1:0] mask_q;
  reg [5:0]  cfg_q    [0:2];
  reg [31:0] per_q    [0:2];
  reg [31:0] pwd_q    [0:2];
  reg [2:0]  pin_s1_q;
  reg [2:0]  pin_s2_q;
  reg        core_evt_q;

  wire [2:0]  gp_evt;
  wire [2:0]  gp_ovr;
  wire [2:0]  cap_vld;
  wire [31:0] gp_cnt   [0:2];
  wire [31:0] cap_per  [0:2];
  wire [31:0] cap_wid  [0:2];
  wire [2:0]  cnt_wr;
  wire        gp_hit;
  wire [1:0]  gp_idx;
  wire [1:0]  gp_sub;
  wire [7:0]  gp_rel;
  wire [`MMTU_IRQ_W-1:0] evt;

  assign gp_rel = i_addr - `MMTU_GPT_BASE;
  assign gp_hit = (i_addr >= `MMTU_GPT_BASE) && (gp_rel < 8'h30) && (i_addr[1:0] == 2'h0);
  assign gp_idx = gp_rel[5:4];
  assign gp_sub = gp_rel[3:2];

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser: two flops before any logic
  always @(posedge i_clk) begin
    if (i_rst) begin
      // pulled-up idle level, so no false edge follows reset
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
    end else begin
      pin_s1_q <= i_tmr_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // general timers, one per channel
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gp
      wire wr_sel;
      // compare at full width, the loop index is an integer
      assign wr_sel    = i_wr && gp_hit && ({30'h0, gp_idx} == g);
      assign cnt_wr[g] = wr_sel && (gp_sub == `MMTU_GPT_CNT_SUB);

      always @(posedge i_clk) begin
        if (i_rst) begin
          cfg_q[g] <= `MMTU_CFG_RST;
          per_q[g] <= `MMTU_WORD_RST;
          pwd_q[g] <= `MMTU_WORD_RST;
        end else begin
          if (wr_sel && (gp_sub == `MMTU_GPT_CFG_SUB)) begin
            cfg_q[g] <= i_wdata[5:0];
          end
          // capture mode writes measurements back, hardware wins
          if (cap_vld[g]) begin
            per_q[g] <= cap_per[g];
            pwd_q[g] <= cap_wid[g];
          end else begin
            if (wr_sel && (gp_sub == `MMTU_GPT_PER_SUB)) begin
              per_q[g] <= i_wdata;
            end
            if (wr_sel && (gp_sub == `MMTU_GPT_PWD_SUB)) begin
              pwd_q[g] <= i_wdata;
            end
          end
        end
      end

      mmtu_gp_timer u_tmr (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_en         (ctrl_q[g]),
        .i_cfg        (cfg_q[g]),
        .i_period     (per_q[g]),
        .i_width      (pwd_q[g]),
        .i_cnt_wr     (cnt_wr[g]),
        .i_cnt_wdata  (i_wdata),
        .i_pin_sync   (pin_s2_q[g]),
        .o_pin_out    (o_tmr_pin[g]),
        .o_pin_oe_n   (o_tmr_pin_oe_n[g]),
        .o_count      (gp_cnt[g]),
        .o_cap_period (cap_per[g]),
        .o_cap_width  (cap_wid[g]),
        .o_cap_valid  (cap_vld[g]),
        .o_event      (gp_evt[g]),
        .o_overrun    (gp_ovr[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // control, core timer and interrupt registers
  assign evt = {gp_ovr, gp_evt & {cfg_q[2][3], cfg_q[1][3], cfg_q[0][3]}, core_evt_q};

  always @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q     <= 3'h0;
      core_cfg_q <= 2'h0;
      core_per_q <= `MMTU_CORE_PER_RST;
      core_cnt_q <= `MMTU_WORD_RST;
      core_evt_q <= 1'b0;
      stat_q     <= 7'h00;
      mask_q     <= 7'h00;
      o_core_expiry_output_pin <= 1'b0;
    end else begin
      core_evt_q <= 1'b0;
      if (i_wr && (i_addr == `MMTU_CTRL_OFF)) begin
        ctrl_q <= i_wdata[2:0]; // per timer enable
      end
      if (i_wr && (i_addr == `MMTU_CORE_CFG_OFF)) begin
        core_cfg_q <= i_wdata[1:0];
      end
      if (i_wr && (i_addr == `MMTU_CORE_PER_OFF)) begin
        core_per_q <= i_wdata;
      end
      if (i_wr && (i_addr == `MMTU_IRQ_MASK_OFF)) begin
        mask_q <= i_wdata[6:0];
      end
      // core timer counts down, reloads and interrupts
      if (i_wr && (i_addr == `MMTU_CORE_CNT_OFF)) begin
        core_cnt_q <= i_wdata;
      end else if (core_cfg_q[`MMTU_CORE_EN_BIT]) begin
        if (core_cnt_q == 32'h0) begin
          core_cnt_q <= core_per_q;
          core_evt_q <= 1'b1;
        end else begin
          core_cnt_q <= core_cnt_q - 32'h1;
        end
      end
      // expiry pin pulses one cycle, held low when not selected
      o_core_expiry_output_pin <= core_cfg_q[`MMTU_CORE_PIN_BIT] &&
                                  core_cfg_q[`MMTU_CORE_EN_BIT] &&
                                  (core_cnt_q == 32'h0);
      // write one clears; a same-cycle event wins over the clear
      stat_q <= (stat_q & ~((i_wr && (i_addr == `MMTU_IRQ_STAT_OFF)) ? i_wdata[6:0] : 7'h00))
                | evt;
    end
  end

  assign o_irq = |(stat_q & mask_q);

  //////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      if (gp_hit) begin
        case (gp_sub)
          `MMTU_GPT_CFG_SUB: o_rdata <= {26'h0, cfg_q[gp_idx]};
          `MMTU_GPT_CNT_SUB: o_rdata <= gp_cnt[gp_idx];
          `MMTU_GPT_PER_SUB: o_rdata <= per_q[gp_idx];
          default:           o_rdata <= pwd_q[gp_idx];
        endcase
      end else begin
        case (i_addr)
          `MMTU_CTRL_OFF:     o_rdata <= {29'h0, ctrl_q};
          `MMTU_CORE_CFG_OFF: o_rdata <= {30'h0, core_cfg_q};
          `MMTU_CORE_PER_OFF: o_rdata <= core_per_q;
          `MMTU_CORE_CNT_OFF: o_rdata <= core_cnt_q;
          `MMTU_IRQ_STAT_OFF: o_rdata <= {25'h0, stat_q};
          `MMTU_IRQ_MASK_OFF: o_rdata <= {25'h0, mask_q};
          default:            o_rdata <= 32'h0;
        endcase
      end
    end else begin
      o_rdata <= 32'h0;
    end
  end

endmodule
`default_nettype wire

// ---- inc/mmtu_map.vh ----
// Purpose: register map and constants of the multi mode timer unit
// Assumes: plain register port, 32-bit data, word-aligned byte addresses
// Notes:   all offsets and fields, and the config, word and core period reset values, live here
//
// Behaviour
// - a core timer raises a periodic software interrupt on each expiry
// - three general-purpose timers each raise interrupts: each period in waveform, each measurement in capture, after period edges in watchdog
// - each general-purpose timer runs in one mode: waveform, width capture or event watchdog
// - core timer can drive the expiry output pin when software enables it
// - each general-purpose timer owns one two-way pin, output or input by mode
// - each general-purpose timer holds a 6-bit config and 32-bit count, period, width
// - one shared control register enables each general-purpose timer independently; the core timer has its own enable bit in its config
`ifndef MMTU_MAP_VH
`define MMTU_MAP_VH

// register offsets (byte addresses)
`define MMTU_CTRL_OFF      8'h00
`define MMTU_CORE_CFG_OFF  8'h04
`define MMTU_CORE_PER_OFF  8'h08
`define MMTU_CORE_CNT_OFF  8'h0c
`define MMTU_IRQ_STAT_OFF  8'h10
`define MMTU_IRQ_MASK_OFF  8'h14
// general timer n sits at base + n * stride
`define MMTU_GPT_BASE      8'h20
`define MMTU_GPT_STRIDE    8'h10
`define MMTU_GPT_CFG_SUB   2'h0
`define MMTU_GPT_CNT_SUB   2'h1
`define MMTU_GPT_PER_SUB   2'h2
`define MMTU_GPT_PWD_SUB   2'h3

// timer configuration fields
`define MMTU_CFG_W         6
`define MMTU_CFG_MODE_LO   0
`define MMTU_CFG_MODE_HI   1
`define MMTU_CFG_POL_BIT   2
`define MMTU_CFG_IRQ_BIT   3
`define MMTU_MODE_OFF      2'h0
`define MMTU_MODE_PWM      2'h1
`define MMTU_MODE_CAPT     2'h2
`define MMTU_MODE_WDOG     2'h3

// core timer config fields
`define MMTU_CORE_EN_BIT   0
`define MMTU_CORE_PIN_BIT  1

// interrupt status layout: bit0 core, bit1..3 general timers, bit4..6 overrun
`define MMTU_IRQ_W         7

// reset values
`define MMTU_CFG_RST       6'h00
`define MMTU_WORD_RST      32'h0000_0000
`define MMTU_CORE_PER_RST  32'h0000_ffff

`endif

// ---- rtl/mmtu_gp_timer.v ----
// Purpose: one general-purpose timer with its own pin
// Assumes: pin input already synchronised by the parent
// Notes:   count wraps to zero at the period register in waveform and watchdog modes, holds at all ones in capture; width in cycles
`timescale 1ns/10ps
`default_nettype none
`include "mmtu_map.vh"

module mmtu_gp_timer (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // control
  input  wire        i_en,
  input  wire [5:0]  i_cfg,
  input  wire [31:0] i_period,
  input  wire [31:0] i_width,
  input  wire        i_cnt_wr,
  input  wire [31:0] i_cnt_wdata,
  // pin
  input  wire        i_pin_sync,
  output reg         o_pin_out,
  output wire        o_pin_oe_n,
  // results
  output wire [31:0] o_count,
  output reg  [31:0] o_cap_period,
  output reg  [31:0] o_cap_width,
  output reg         o_cap_valid,
  output reg         o_event,
  output reg         o_overrun
);

  wire [1:0] mode;
  wire       pol;
  reg [31:0] cnt_q;
  reg        pin_d1_q;
  reg        got_first_q;
  wire       rise;
  wire       fall;
  wire       act_edge;
  wire       end_edge;

  assign mode = i_cfg[`MMTU_CFG_MODE_HI:`MMTU_CFG_MODE_LO];
  assign pol  = i_cfg[`MMTU_CFG_POL_BIT];
  assign o_count = cnt_q;
  // pin is an output only in waveform mode, input otherwise
  assign o_pin_oe_n = ~(i_en && (mode == `MMTU_MODE_PWM));

  assign rise = i_pin_sync & ~pin_d1_q;
  assign fall = ~i_pin_sync & pin_d1_q;
  // polarity picks which edge starts the active phase
  assign act_edge = pol ? fall : rise;
  assign end_edge = pol ? rise : fall;

  //////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q        <= `MMTU_WORD_RST;
      pin_d1_q     <= 1'b1; // pulled-up idle level, no false edge
      got_first_q  <= 1'b0;
      o_pin_out    <= 1'b0;
      o_cap_period <= `MMTU_WORD_RST;
      o_cap_width  <= `MMTU_WORD_RST;
      o_cap_valid  <= 1'b0;
      o_event      <= 1'b0;
      o_overrun    <= 1'b0;
    end else begin
      pin_d1_q    <= i_pin_sync;
      o_event     <= 1'b0;
      o_overrun   <= 1'b0;
      o_cap_valid <= 1'b0;
      if (i_cnt_wr) begin
        cnt_q <= i_cnt_wdata;
      end else if (!i_en) begin
        got_first_q <= 1'b0;
        o_pin_out   <= pol;
      end else begin
        case (mode) // one mode at a time
          `MMTU_MODE_PWM: begin
            // active for width cycles, repeat each period
            if (cnt_q + 32'h1 >= i_period) begin
              cnt_q   <= 32'h0;
              o_event <= 1'b1; // periodic interrupt
            end else begin
              cnt_q <= cnt_q + 32'h1;
            end
            // at the wrap the next count is zero: active unless width is zero
            o_pin_out <= ((cnt_q + 32'h1 >= i_period) ? (i_width != 32'h0)
                                                       : (cnt_q + 32'h1 < i_width)) ^ pol;
          end
          `MMTU_MODE_CAPT: begin
            // measure width and period between active edges
            if (cnt_q != 32'hffff_ffff) begin
              cnt_q <= cnt_q + 32'h1;
            end else begin
              o_overrun <= 1'b1;
            end
            if (end_edge && got_first_q) begin
              o_cap_width <= cnt_q;
            end
            if (act_edge) begin
              cnt_q       <= 32'h1;
              got_first_q <= 1'b1;
              if (got_first_q) begin
                o_cap_period <= cnt_q;
                o_cap_valid  <= 1'b1;
                o_event      <= 1'b1;
              end
            end
          end
          `MMTU_MODE_WDOG: begin
            // events count up; interrupt once period events seen
            if (act_edge) begin
              if (cnt_q + 32'h1 >= i_period) begin
                cnt_q   <= 32'h0;
                o_event <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 32'h1;
              end
            end
          end
          default: begin
            cnt_q <= cnt_q;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/mmtu_pin_src.sv ----
// Purpose: far side of the three timer pins
// Assumes: pins carry pull-ups, idle high when released
// Notes:   one square wave, HI high then LO low cycles
`timescale 1ns/10ps
`default_nettype none
module mmtu_pin_src #(
  parameter int HI = 5,
  parameter int LO = 7
) (
  // clock
  input  wire logic       i_clk,
  // control and design side
  input  wire logic       i_run,
  input  wire logic [2:0] i_drv,
  input  wire logic [2:0] i_oe_n,
  // resolved pin level
  output wire logic [2:0] o_wire
);
  // known start, or the wave would stay unknown for good
  logic [7:0] cnt_q = 8'h00;
  logic       src;
  always @(posedge i_clk) begin
    cnt_q <= (!i_run || cnt_q == HI + LO - 1) ? 8'h00 : cnt_q + 8'h01;
  end
  // pull-up wins while stopped
  assign src = i_run ? (cnt_q < HI) : 1'b1;
  // design drives while oe_n low, else source
  assign o_wire = (i_oe_n & {3{src}}) | (~i_oe_n & i_drv);
endmodule
`default_nettype wire

// ---- tb/mmtu_top_sva.sv ----
// Purpose: port level checks of the timer unit
// Assumes: one clock, synchronous reset
// Notes:   bound to mmtu_top below
`timescale 1ns/10ps
`default_nettype none
module mmtu_top_sva (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // register port
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // irq and pins
  input wire logic        o_irq,
  input wire logic        o_core_expiry_output_pin,
  input wire logic [2:0]  i_tmr_pin,
  input wire logic [2:0]  o_tmr_pin,
  input wire logic [2:0]  o_tmr_pin_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ctrl_wr;
    i_wr && i_addr == 8'h00;
  endsequence
  sequence s_ctrl_rd;
    i_rd && i_addr == 8'h00;
  endsequence
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_ctrl_back: assert property (s_ctrl_wr ##2 s_ctrl_rd |=>
    o_rdata[2:0] == $past(i_wdata[2:0], 3)) else $error("control readback wrong");
  chk_unmapped_read: assert property (i_rd && (i_addr == 8'hfc || i_addr[1:0] != 2'h0)
    |=> o_rdata == 32'h0) else $error("unmapped read not zero");
  chk_cfg_width: assert property (i_rd && i_addr inside {8'h20, 8'h30, 8'h40}
    |=> o_rdata[31:6] == 26'h0) else $error("config wider than six bits");
  chk_mask_off: assert property (i_wr && i_addr == 8'h14 && i_wdata[6:0] == 7'h0
    |=> !o_irq) else $error("irq high with all masked");
  chk_core_pulse: assert property ($rose(o_core_expiry_output_pin)
    |=> !o_core_expiry_output_pin) else $error("expiry pulse longer than one cycle");
  chk_ctrl_off: assert property (s_ctrl_wr ##0 (i_wdata[2:0] == 3'h0)
    |-> ##[1:2] o_tmr_pin_oe_n == 3'h7) else $error("pin still driven when disabled");
  chk_after_rst: assert property ($fell(i_rst) |-> o_tmr_pin_oe_n == 3'h7
    && o_tmr_pin == 3'h0 && !o_irq) else $error("pins or irq wrong after reset");
endmodule
bind mmtu_top mmtu_top_sva chk_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_core_expiry_output_pin(o_core_expiry_output_pin), .i_tmr_pin(i_tmr_pin),
  .o_tmr_pin(o_tmr_pin), .o_tmr_pin_oe_n(o_tmr_pin_oe_n)
);
`default_nettype wire

// ---- tb/tb_multi_mode_timer_unit.sv ----
// Purpose: self-checking bench of the timer unit
// Assumes: 125 MHz clock, pin source with 5 high, 7 low
// Notes:   register rows first, then timer scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_multi_mode_timer_unit;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mmtu_row_t;
  mmtu_row_t rows [0:14] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 32'h0000_ffff}, '{1'b0, 8'h14, 32'h0, 32'h0},
    '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b0, 8'h4c, 32'h0, 32'h0},
    '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b1, 8'h08, 32'h1234_5678, 32'h1234_5678},
    '{1'b1, 8'h14, 32'hffff_ffff, 32'h7f}, '{1'b1, 8'h20, 32'hffff_ffff, 32'h3f},
    '{1'b1, 8'h34, 32'ha5a5_0003, 32'ha5a5_0003}, '{1'b1, 8'h4c, 32'hc3, 32'hc3},
    '{1'b1, 8'h00, 32'hffff_fff8, 32'h0}, '{1'b1, 8'hfc, 32'hffff_ffff, 32'h0},
    '{1'b1, 8'h21, 32'hffff_ffff, 32'h0}};
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        run = 1'b1;
  wire  [31:0] o_rdata;
  wire         o_irq;
  wire         pin_c;
  wire  [2:0]  pin_w;
  wire  [2:0]  pin_o;
  wire  [2:0]  pin_oe_n;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  always #4 i_clk = ~i_clk;
  mmtu_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_core_expiry_output_pin(pin_c), .i_tmr_pin(pin_w), .o_tmr_pin(pin_o),
    .o_tmr_pin_oe_n(pin_oe_n));
  mmtu_pin_src #(.HI(5), .LO(7)) src_u (.i_clk(i_clk), .i_run(run), .i_drv(pin_o),
    .i_oe_n(pin_oe_n), .o_wire(pin_w));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // generous bound, the tests need about 400 cycles
  initial begin
    #160000;
    n_mismatch++;
    results();
  end
  initial begin
    logic [31:0] d;
    int          n;
    int          hi;
    int          rises;
    logic        prev;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    // core timer: count 4, period 9, pin on
    wr(8'h0c, 32'h4);
    wr(8'h08, 32'h9);
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h3);
    n = 0;
    while (pin_c !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    tick(1);
    n = 1;
    while (pin_c !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(n, 10);
    chk(o_irq, 1'b1);
    wr(8'h14, 32'h0);
    chk(o_irq, 1'b0);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h7f);
    rd(8'h10, d);
    chk(d[6:0], 7'h0);
    // timer 0 waveform: period 8, width 3, irq on
    wr(8'h28, 32'h8);
    wr(8'h2c, 32'h3);
    wr(8'h20, 32'h9);
    wr(8'h14, 32'h7f);
    wr(8'h00, 32'h1);
    tick(4);
    chk(pin_oe_n, 3'h6);
    prev = pin_o[0];
    hi = 0;
    rises = 0;
    for (int k = 0; k < 16; k++) begin
      tick(1);
      hi += pin_o[0];
      rises += (pin_o[0] && !prev);
      prev = pin_o[0];
    end
    chk(hi, 6);
    chk(rises, 2);
    chk(o_irq, 1'b1);
    // timer 1 capture of the 5 high, 7 low source
    wr(8'h30, 32'h2);
    wr(8'h00, 32'h3);
    tick(80);
    rd(8'h38, d);
    chk(d, 32'hc);
    rd(8'h3c, d);
    chk(d, 32'h5);
    // timer 2 watchdog on three edges; timer 1 capture has its irq bit off, so no status event
    wr(8'h10, 32'h7f);
    wr(8'h48, 32'h3);
    wr(8'h40, 32'hb);
    wr(8'h00, 32'h7);
    tick(60);
    rd(8'h10, d);
    chk(d[3:0], 4'ha);
    // inverted polarity on timer 0: active phase now low
    wr(8'h20, 32'hd);
    tick(2);
    hi = 0;
    for (int k = 0; k < 16; k++) begin
      tick(1);
      hi += pin_o[0];
    end
    chk(hi, 10);
    // source stopped, pull-up holds the pin high, watchdog stays quiet
    run <= 1'b0;
    tick(20);
    wr(8'h10, 32'h7f);
    tick(60);
    rd(8'h10, d);
    chk(d[3], 1'b0);
    // reset in mid-run
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    tick(1);
    chk(o_irq, 1'b0);
    rd(8'h00, d);
    chk(d, 32'h0);
    rd(8'h08, d);
    chk(d, 32'h0000_ffff);
    results();
  end
endmodule
`default_nettype wire
